// *** rtl/mtc_metering_mode_temp_control.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.vh"

// Behaviour
// - rms refresh every 400 ms when mode bit 8 is 0, 800 ms when 1
// - mode bit 9 selects 50 Hz (0) or 60 Hz (1) mains
// - mode bit 11 picks channel A (0) or B (1) energy pulses
// - mode bit 12 picks energy pulses (0) or the alarm (1) on the pin
// - temperature control bit 15 low enables measurement; resets low
// - temperature control bit 14 picks temperature alarm or channel A overcurrent for the pin
// - bits 13:12 pick sensor: auto, auto, internal, external; reset 00
// - bits 11:10 pick interval 50/100/200/400 ms; reset 01
// - bits 9:0 hold alarm threshold; 0x3FF means no alarm
// - temperature alarm when external result at or above threshold
// - mode and temperature control registers writable only while write-protect holds 0x55
// - external temperature result is a 10-bit read-only register
module mtc_metering_mode_temp_control #(
  parameter RMS_BASE_CYCLES = `MTC_RMS_SHORT_CYCLES,
  parameter MEAS_BASE_CYCLES = `MTC_MEAS_BASE_CYCLES
) (
  // clock, reset, enable
  input wire core_clk,
  input wire rst,
  input wire ce,
  // register port from the host link decoder
  input wire [7:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [23:0] reg_rdata,
  output reg reg_rvalid,
  // measurement sources
  input wire [9:0] ext_temp_in,
  input wire ext_temp_valid,
  input wire pulse_a_in,
  input wire pulse_b_in,
  input wire overcurrent_a_in,
  // control outputs
  output reg energy_pulse_pin,
  output reg rms_refresh_tick,
  output reg mains_60hz,
  output reg temp_measure_enable,
  output reg [1:0] temp_sensor_sel,
  output reg temp_measure_tick,
  output reg temperature_alarm
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // ce low holds every flop below, outputs included, so the pins freeze too
  reg [15:0] operating_mode_config;
  reg [15:0] temperature_control;
  reg [7:0] user_write_protect;
  reg [9:0] external_temperature_result;
  reg [27:0] rms_cnt;
  reg [27:0] meas_cnt;

  // key compare is exact; any other value, the reset value included, locks
  wire unlocked = (user_write_protect == `MTC_WRPROT_KEY);
  wire [9:0] threshold = temperature_control[`MTC_TC_THR_HI:0];

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  // timer bases cut to the counter width once; longest period is 800 ms
  localparam [27:0] RMS_BASE = RMS_BASE_CYCLES[27:0];
  localparam [27:0] MEAS_BASE = MEAS_BASE_CYCLES[27:0];

  // refresh period doubles with the select bit; 800 ms still fits 28 bits
  wire [27:0] rms_period = operating_mode_config[`MTC_MODE_RMS_SEL] ?
    (RMS_BASE << 1) : RMS_BASE;

  // interval field is a power-of-two multiple of the 50 ms base
  wire [1:0] ivl_sel = temperature_control[`MTC_TC_IVL_HI:`MTC_TC_IVL_LO];
  wire [27:0] meas_period = MEAS_BASE << ivl_sel;

  // sensor field: 00 and 01 both mean automatic
  wire [1:0] sensor_field = temperature_control[`MTC_TC_SENSOR_HI:`MTC_TC_SENSOR_LO];
  wire [1:0] next_sensor_sel = sensor_field[1] ? sensor_field : 2'b00;

  // threshold of all ones disables the alarm rather than matching 1023
  wire temp_hit = (threshold != `MTC_TC_THR_NONE) &&
    (external_temperature_result >= threshold);
  wire alarm_sig = temperature_control[`MTC_TC_ALARM_SRC] ?
    overcurrent_a_in : temp_hit;
  wire energy_sel = operating_mode_config[`MTC_MODE_PULSE_CH] ?
    pulse_b_in : pulse_a_in;

  // ----------------------------------------------------------------
  // pulse pin source
  // ----------------------------------------------------------------
  // one mux ahead of the pin flop, so a mode write never glitches the pin
  reg next_pin;
  always @* begin
    next_pin = energy_sel;
    if (operating_mode_config[`MTC_MODE_PIN_FUNC]) begin
      next_pin = alarm_sig;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // write-protect register itself is always writable, else lockout is permanent
  // a locked write is dropped with no flag; the host reads back to confirm
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      operating_mode_config <= `MTC_MODE_RESET;
      temperature_control <= `MTC_TEMP_CTRL_RESET;
      user_write_protect <= `MTC_WRPROT_RESET;
    end else if (ce && reg_wr) begin
      if (reg_addr == `MTC_ADDR_WRPROT) begin
        user_write_protect <= reg_wdata[7:0];
      end
      if (unlocked && reg_addr == `MTC_ADDR_MODE) begin
        operating_mode_config <= reg_wdata[15:0] & `MTC_MODE_WMASK;
      end
      if (unlocked && reg_addr == `MTC_ADDR_TEMP_CTRL) begin
        temperature_control <= reg_wdata[15:0];
      end
    end
  end

  // external result register; the host cannot write it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      external_temperature_result <= 10'h000;
    end else if (ce && ext_temp_valid) begin
      external_temperature_result <= ext_temp_in;
    end
  end

  // ----------------------------------------------------------------
  // register reads, one cycle latency
  // ----------------------------------------------------------------
  // address decode; offsets with no register read as zero
  reg [23:0] next_rdata;
  always @* begin
    next_rdata = 24'h00_0000;
    case (reg_addr)
      `MTC_ADDR_EXT_TEMP: next_rdata = {14'h0000, external_temperature_result};
      `MTC_ADDR_MODE: next_rdata = {8'h00, operating_mode_config};
      `MTC_ADDR_WRPROT: next_rdata = {16'h0000, user_write_protect};
      `MTC_ADDR_TEMP_CTRL: next_rdata = {8'h00, temperature_control};
      default: next_rdata = 24'h00_0000;
    endcase
  end

  // read data holds until the next read, so a slow host can fetch it late
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 24'h00_0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // periodic timers
  // ----------------------------------------------------------------
  // a shortened period takes effect at once: counter resets if past it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rms_cnt <= 28'h000_0000;
      rms_refresh_tick <= 1'b0;
    end else if (ce) begin
      if (rms_cnt >= rms_period - 28'h000_0001) begin
        rms_cnt <= 28'h000_0000;
        rms_refresh_tick <= 1'b1;
      end else begin
        rms_cnt <= rms_cnt + 28'h000_0001;
        rms_refresh_tick <= 1'b0;
      end
    end
  end

  // measurement timer halts and restarts from zero while switched off
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meas_cnt <= 28'h000_0000;
      temp_measure_tick <= 1'b0;
    end else if (ce) begin
      if (temperature_control[`MTC_TC_MEAS_OFF]) begin
        meas_cnt <= 28'h000_0000;
        temp_measure_tick <= 1'b0;
      end else if (meas_cnt >= meas_period - 28'h000_0001) begin
        meas_cnt <= 28'h000_0000;
        temp_measure_tick <= 1'b1;
      end else begin
        meas_cnt <= meas_cnt + 28'h000_0001;
        temp_measure_tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------
  // every output leaves from a flop; the host link sees no decode ripple
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      energy_pulse_pin <= 1'b0;
      mains_60hz <= 1'b0;
      temp_measure_enable <= 1'b0;
      temp_sensor_sel <= 2'b00;
      temperature_alarm <= 1'b0;
    end else if (ce) begin
      energy_pulse_pin <= next_pin;
      mains_60hz <= operating_mode_config[`MTC_MODE_FREQ_SEL];
      temp_measure_enable <= ~temperature_control[`MTC_TC_MEAS_OFF];
      temp_sensor_sel <= next_sensor_sel;
      temperature_alarm <= temp_hit;
    end
  end

endmodule

`default_nettype wire

// *** rtl/mtc_defines.vh ***
`ifndef MTC_DEFINES_VH
`define MTC_DEFINES_VH

// register offsets on the internal register port
`define MTC_ADDR_EXT_TEMP 8'h0F
`define MTC_ADDR_MODE 8'h18
`define MTC_ADDR_WRPROT 8'h1A
`define MTC_ADDR_TEMP_CTRL 8'h1B

// reset values and the write-protect key
`define MTC_MODE_RESET 16'h0000
`define MTC_TEMP_CTRL_RESET 16'h07FF
`define MTC_WRPROT_RESET 8'h00
`define MTC_WRPROT_KEY 8'h55

// writable bits of the mode register (8, 9, 11, 12)
`define MTC_MODE_WMASK 16'h1B00

// mode register fields
`define MTC_MODE_RMS_SEL 8
`define MTC_MODE_FREQ_SEL 9
`define MTC_MODE_PULSE_CH 11
`define MTC_MODE_PIN_FUNC 12

// temperature control fields
`define MTC_TC_MEAS_OFF 15
`define MTC_TC_ALARM_SRC 14
`define MTC_TC_SENSOR_HI 13
`define MTC_TC_SENSOR_LO 12
`define MTC_TC_IVL_HI 11
`define MTC_TC_IVL_LO 10
`define MTC_TC_THR_HI 9
`define MTC_TC_THR_NONE 10'h3FF

// timing: figures in ms, clock in MHz, counts derived
`define MTC_CLK_MHZ 125
`define MTC_RMS_SHORT_MS 400
`define MTC_MEAS_BASE_MS 50
`define MTC_RMS_SHORT_CYCLES (`MTC_RMS_SHORT_MS * `MTC_CLK_MHZ * 1000)
`define MTC_MEAS_BASE_CYCLES (`MTC_MEAS_BASE_MS * `MTC_CLK_MHZ * 1000)

`endif

// *** testbench/mtc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// host side of the register link
// ------------------------------
module mtc_host_model (
  // register link
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [23:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 34'h0;
  // one word per edge; strobe stays up across back to back calls
  task automatic acc(input logic [7:0] a, input logic [23:0] d, input logic w);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
  endtask
  task automatic unlock;
    acc(8'h1A, 24'h00_0055, 1'b1);
  endtask
  // released lines invert so a stale word never looks valid
  task automatic idle;
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~reg_addr, ~reg_wdata, 2'b00};
  endtask
endmodule
`default_nettype wire

// *** testbench/mtc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// register port and timer checks
// ---------------------------
module mtc_monitor #(parameter RMS_BASE_CYCLES = 40) (
  input wire core_clk, input wire rst, input wire ce,
  input wire [7:0] reg_addr, input wire reg_wr, input wire reg_rd,
  input wire [23:0] reg_rdata, input wire reg_rvalid,
  input wire rms_refresh_tick, input wire mains_60hz, input wire temp_measure_enable,
  input wire [1:0] temp_sensor_sel, input wire temp_measure_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int cnt;
  logic seen;
  // gap since last tick; a mode write may restart the period, so skip one tick
  always @(posedge core_clk or posedge rst)
    if (rst) {cnt, seen} <= 0;
    else if (ce) begin
      cnt <= rms_refresh_tick ? 0 : cnt + 1;
      seen <= (reg_wr && reg_addr == 8'h18) ? 1'b0 : seen | rms_refresh_tick;
    end
  sequence s_quiet_rd(logic [7:0] a);
    reg_rvalid && $past(reg_addr) == a && !$past(reg_wr) && !$past(reg_wr, 2);
  endsequence
  a_rvalid_pulse: assert property (ce |=> reg_rvalid == $past(reg_rd)) else $error("read answer late");
  a_mode_reserved: assert property (reg_rvalid && $past(reg_addr) == 8'h18 |->
    (reg_rdata & 24'hFF_E4FF) == 0) else $error("reserved mode bits set");
  a_mains_follow: assert property (s_quiet_rd(8'h18) |-> mains_60hz == reg_rdata[9]) else $error("mains");
  a_meas_enable: assert property (s_quiet_rd(8'h1B) |-> temp_measure_enable != reg_rdata[15]) else $error("meas");
  a_sensor_fold: assert property (s_quiet_rd(8'h1B) |->
    temp_sensor_sel == (reg_rdata[13] ? reg_rdata[13:12] : 2'b00)) else $error("sensor select");
  a_unmapped_zero: assert property (reg_rvalid && !($past(reg_addr) inside {8'h0F, 8'h18, 8'h1A, 8'h1B}) |->
    reg_rdata == 0) else $error("unmapped read");
  a_rms_period: assert property (ce && rms_refresh_tick && seen |->
    cnt + 1 == RMS_BASE_CYCLES || cnt + 1 == 2 * RMS_BASE_CYCLES) else $error("refresh period");
  a_meas_held: assert property (!temp_measure_enable && $past(!temp_measure_enable) |->
    !temp_measure_tick) else $error("tick while off");
endmodule
bind mtc_metering_mode_temp_control mtc_monitor #(.RMS_BASE_CYCLES(RMS_BASE_CYCLES)) mtc_monitor_inst (
  .core_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .rms_refresh_tick,
  .mains_60hz, .temp_measure_enable, .temp_sensor_sel, .temp_measure_tick);
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ---------------------------
  // stimulus and read scoreboard
  // ---------------------------
  logic core_clk = 1'b0, rst = 1'b1, ext_temp_valid = 1'b0, pulse_a_in = 1'b0, pulse_b_in = 1'b0;
  logic overcurrent_a_in = 1'b0, ce = 1'b1;
  logic [9:0] ext_temp_in = 10'h000, t;
  logic [3:0] r;
  wire [7:0] reg_addr;
  wire [23:0] reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, energy_pulse_pin, rms_refresh_tick, mains_60hz;
  wire temp_measure_enable, temp_measure_tick, temperature_alarm;
  wire [1:0] temp_sensor_sel;
  int fails = 0, n_checks = 0, n;
  logic [23:0] exp_q[$];
  always #4 core_clk = ~core_clk;
  mtc_metering_mode_temp_control #(.RMS_BASE_CYCLES(40), .MEAS_BASE_CYCLES(10)) mtc_metering_mode_temp_control_inst (
    .core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .ext_temp_in,
    .ext_temp_valid, .pulse_a_in, .pulse_b_in, .overcurrent_a_in, .energy_pulse_pin, .rms_refresh_tick,
    .mains_60hz, .temp_measure_enable, .temp_sensor_sel, .temp_measure_tick, .temperature_alarm);
  mtc_host_model mtc_host_model_inst (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    mtc_host_model_inst.acc(a, {8'h00, d}, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    mtc_host_model_inst.acc(a, 24'h00_0000, 1'b0);
  endtask
  // release the link, then give registered outputs time to land
  task automatic settle;
    mtc_host_model_inst.idle();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic load(input logic [9:0] v);
    @(negedge core_clk);
    {ext_temp_in, ext_temp_valid} = {v, 1'b1};
    @(negedge core_clk);
    ext_temp_valid = 1'b0;
  endtask
  // first pass only syncs to a tick, second pass measures
  task automatic gap(input logic tm, input int want);
    repeat (2) begin
      n = 0;
      do begin @(negedge core_clk); n++; end while ((tm ? temp_measure_tick : rms_refresh_tick) !== 1'b1 && n < 999);
    end
    check(24'(n), 24'(want));
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // each read answer meets the oldest noted expectation
  always @(negedge core_clk) if (reg_rvalid === 1'b1) check(reg_rdata, exp_q.pop_front());
  initial begin #400_000; fails++; give_verdict; end
  initial begin
    void'($urandom(32'hbd24));
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    wr(8'h18, 16'hFFFF);
    wr(8'h0F, 16'h0123);
    rd(8'h18, 24'h00_0000);
    rd(8'h1B, 24'h00_07FF);
    rd(8'h0F, 24'h00_0000);
    rd(8'h30, 24'h00_0000);
    mtc_host_model_inst.unlock();
    wr(8'h18, 16'hFFFF);
    rd(8'h18, 24'h00_1B00);
    settle;
    rd(8'h18, 24'h00_1B00);
    settle;
    check(24'(mains_60hz), 24'h00_0001);
    gap(1'b0, 80);
    wr(8'h18, 16'h0000);
    settle;
    rd(8'h18, 24'h00_0000);
    settle;
    check(24'(mains_60hz), 24'h00_0000);
    gap(1'b0, 40);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1B, {2'b00, i[1:0], i[1:0], 10'h3FF});
      settle;
      rd(8'h1B, {8'h00, 2'b00, i[1:0], i[1:0], 10'h3FF});
      settle;
      check(24'(temp_sensor_sel), i[1] ? 24'(i) : 24'h00_0000);
      gap(1'b1, 10 << i);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h18, {3'b000, i[1:0], 11'h000});
      wr(8'h1B, {1'b0, i[2], 14'h07FF});
      settle;
      r = 4'($urandom);
      {pulse_a_in, pulse_b_in, overcurrent_a_in} = r[2:0];
      repeat (2) @(negedge core_clk);
      check(24'(energy_pulse_pin), 24'(i[1] ? (i[2] & r[0]) : (i[0] ? r[1] : r[2])));
    end
    t = 10'($urandom_range(1, 1022));
    wr(8'h18, 16'h1000);
    wr(8'h1B, {6'h01, t});
    settle;
    for (int k = -1; k < 2; k++) begin
      load(t + 10'(k));
      rd(8'h0F, {14'h0000, t + 10'(k)});
      settle;
      check(24'(temperature_alarm), 24'(k >= 0));
      check(24'(energy_pulse_pin), 24'(k >= 0));
    end
    wr(8'h1B, 16'h87FF);
    load(10'h3FF);
    rd(8'h1B, 24'h00_87FF);
    wr(8'h0F, 16'h0123);
    rd(8'h0F, 24'h00_03FF);
    settle;
    check(24'(temperature_alarm), 24'h00_0000);
    check(24'(temp_measure_enable), 24'h00_0000);
    repeat (100) @(negedge core_clk) check(24'(temp_measure_tick), 24'h00_0000);
    ce = 1'b0; // frozen core must drop this write
    wr(8'h1B, 16'h0000);
    settle;
    ce = 1'b1;
    rd(8'h1B, 24'h00_87FF);
    wr(8'h1A, 16'h00AA);
    wr(8'h18, 16'h1B00);
    rd(8'h18, 24'h00_1000);
    settle;
    check(24'(exp_q.size()), 24'h00_0000);
    give_verdict;
  end
endmodule
`default_nettype wire
